// [hw/sp4_serial_port.sv]
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
module sp4_serial_port #(
  parameter int ADDR_W = 8
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic timer1_input_clock,
  input wire logic [2:0] wide_timer_ovf,
  input wire logic serial_rx_pin_in,
  output logic serial_rx_pin_out,
  output logic serial_rx_pin_oe_n,
  output logic serial_tx_pin,
  output logic irq
);
  if (ADDR_W < 5 || ADDR_W > 8) begin : g_chk
    $error("ADDR_W must lie between 5 and 8");
  end

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_BITS = 2'b11
  } sp4_rx_st_t;

  function automatic logic addr_hit(input logic [7:0] d,
                                    input logic [7:0] a,
                                    input logic [7:0] m);
    logic [7:0] bc;
    bc = a | m;
    addr_hit = (((d ^ a) & m) == 8'h00) || ((d & bc) == bc);
  endfunction

  // Registers
  logic [1:0] mode;
  logic mpe, ren, tb8, rb8, ti, ri, int_en, baud_double;
  logic [1:0] tx_src, rx_src;
  logic [7:0] rx_buf, t1_reload, my_addr, my_mask;

  wire [7:0] a8 = 8'(reg_addr);
  wire wr_ctrl = reg_wr && (a8 == sp4_pkg::OFS_CTRL);
  wire wr_buf = reg_wr && (a8 == sp4_pkg::OFS_BUF);
  wire wr_stat = reg_wr && (a8 == sp4_pkg::OFS_STAT);
  wire wr_ien = reg_wr && (a8 == sp4_pkg::OFS_IEN);
  wire wr_t1 = reg_wr && (a8 == sp4_pkg::OFS_T1RL);
  wire wr_addr = reg_wr && (a8 == sp4_pkg::OFS_ADDR);
  wire wr_mask = reg_wr && (a8 == sp4_pkg::OFS_MASK);
  wire is_m0 = (mode == sp4_pkg::SP4_M0);
  wire nine = mode[1];
  wire fixed = (mode == sp4_pkg::SP4_M2);
  wire [3:0] nbits = nine ? sp4_pkg::BITS_9N : sp4_pkg::BITS_8N;
  wire [7:0] ctrl_rd = {mode, mpe, ren, tb8, rb8, ti, ri};
  wire [7:0] stat_rd = {3'h0, baud_double, tx_src, rx_src};

  // Timer 1 in auto-reload form
  logic [7:0] t1_cnt;
  logic t1_ovf;
  wire t1_roll = timer1_input_clock && (t1_cnt == sp4_pkg::T1_TOP);
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      t1_cnt <= sp4_pkg::RST_BYTE;
      t1_ovf <= 1'b0;
    end else begin
      if (timer1_input_clock)
        t1_cnt <= t1_roll ? t1_reload : t1_cnt + 8'h01;
      t1_ovf <= t1_roll;
    end
  end

  // Baud generators, one per direction
  sp4_baud_if tx_bif();
  sp4_baud_if rx_bif();
  assign tx_bif.src = tx_src;
  assign rx_bif.src = rx_src;
  wire [3:0] ovf_all = {wide_timer_ovf, t1_ovf};
  sp4_baud_gen u_tx_baud (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .ovf(ovf_all),
    .fixed_rate(fixed),
    .baud_double(baud_double),
    .bif(tx_bif)
  );
  sp4_baud_gen u_rx_baud (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .ovf(ovf_all),
    .fixed_rate(fixed),
    .baud_double(baud_double),
    .bif(rx_bif)
  );

  // Rx pin synchroniser; rx_s2 is the sampled level, and rx_s3 with rx_s2 detects the falling edge
  logic rx_s1, rx_s2, rx_s3;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_s3 <= 1'b1;
    end else begin
      rx_s1 <= serial_rx_pin_in;
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
    end
  end
  wire rx_fall = rx_s3 && !rx_s2;

  // Mode 0 shifter, half duplex, device is clock master
  logic m0_act, m0_rx, m0_fin;
  logic [3:0] m0_ph;
  logic [2:0] m0_bit;
  logic [7:0] m0_sh;
  wire m0_start_tx = is_m0 && wr_buf && !m0_act;
  wire m0_start_rx = is_m0 && ren && !ri && !m0_act && !m0_fin
                     && !wr_buf;
  wire m0_edge = m0_act && (m0_ph == sp4_pkg::M0_LAST);
  wire m0_end = m0_edge && (m0_bit == sp4_pkg::M0_BITS_LAST);
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      m0_act <= 1'b0;
      m0_rx <= 1'b0;
      m0_fin <= 1'b0;
      m0_ph <= 4'h0;
      m0_bit <= 3'h0;
      m0_sh <= 8'h00;
    end else begin
      m0_fin <= m0_end && m0_rx;
      if (m0_start_tx || m0_start_rx) begin
        m0_act <= 1'b1;
        m0_rx <= m0_start_rx;
        m0_ph <= 4'h0;
        m0_bit <= 3'h0;
        m0_sh <= m0_start_tx ? reg_wdata : 8'h00;
      end else if (m0_act) begin
        m0_ph <= m0_edge ? 4'h0 : m0_ph + 4'h1;
        if (m0_edge) begin
          m0_bit <= m0_bit + 3'h1;
          m0_sh <= {m0_rx ? rx_s2 : 1'b1, m0_sh[7:1]};
          if (m0_end)
            m0_act <= 1'b0;
        end
      end
    end
  end

  // Async transmitter
  logic tx_busy;
  logic [10:0] tx_sh;
  logic [3:0] tx_left, tx_os;
  wire tx_bit_end = tx_busy && tx_bif.tick && (tx_os == sp4_pkg::OS_LAST);
  wire tx_start = !is_m0 && wr_buf && !tx_busy;
  wire tx_stop_now = tx_bit_end && (tx_left == 4'h2);
  wire tx_bit9 = nine ? tb8 : 1'b1;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tx_busy <= 1'b0;
      tx_sh <= 11'h7ff;
      tx_left <= 4'h0;
      tx_os <= 4'h0;
    end else if (tx_start) begin
      tx_busy <= 1'b1;
      tx_sh <= {1'b1, tx_bit9, reg_wdata, 1'b0};
      tx_left <= nbits;
      tx_os <= 4'h0;
    end else if (tx_busy && tx_bif.tick) begin
      tx_os <= tx_os + 4'h1;
      if (tx_bit_end) begin
        tx_sh <= {1'b1, tx_sh[10:1]};
        tx_left <= tx_left - 4'h1;
        if (tx_left == 4'h1)
          tx_busy <= 1'b0;
      end
    end
  end

  // Async receiver
  sp4_rx_st_t rx_st;
  logic [3:0] rx_os, rx_left;
  logic [9:0] rx_sh;
  wire rx_samp = rx_bif.tick && (rx_os == sp4_pkg::OS_LAST);
  wire rx_last = (rx_st == RX_BITS) && rx_samp && (rx_left == 4'h1);
  wire [9:0] rx_word = {rx_s2, rx_sh[9:1]};
  wire [7:0] rx_data = nine ? rx_word[7:0] : rx_word[8:1];
  wire rx_bit9 = nine ? rx_word[8] : rx_word[9];
  wire rx_ok8 = !mpe || rx_word[9];
  wire rx_ok9 = !mpe || (rx_word[8]
                && addr_hit(rx_data, my_addr, my_mask));
  wire rx_acc = rx_last && !ri && (nine ? rx_ok9 : rx_ok8);
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rx_st <= RX_IDLE;
      rx_os <= 4'h0;
      rx_left <= 4'h0;
      rx_sh <= 10'h000;
    end else begin
      case (rx_st)
        RX_IDLE: begin
          rx_os <= 4'h0;
          if (!is_m0 && ren && rx_fall)
            rx_st <= RX_START;
        end
        RX_START: begin
          if (rx_bif.tick) begin
            rx_os <= rx_os + 4'h1;
            if (rx_os == sp4_pkg::OS_MID) begin
              rx_os <= 4'h0;
              rx_left <= nbits - 4'h1;
              rx_st <= rx_s2 ? RX_IDLE : RX_BITS;
            end
          end
        end
        RX_BITS: begin
          if (rx_bif.tick)
            rx_os <= rx_os + 4'h1;
          if (rx_samp) begin
            rx_sh <= rx_word;
            rx_left <= rx_left - 4'h1;
            if (rx_left == 4'h1)
              rx_st <= RX_IDLE;
          end
        end
        default: rx_st <= RX_IDLE;
      endcase
    end
  end

  // Flags: hardware set wins over a software write in the same cycle
  wire ti_set = (m0_end && !m0_rx) || tx_stop_now;
  wire ri_set = m0_fin || rx_acc;
  wire next_ti = ti_set || (wr_ctrl ? reg_wdata[sp4_pkg::CTL_TI] : ti);
  wire next_ri = ri_set || (wr_ctrl ? reg_wdata[sp4_pkg::CTL_RI] : ri);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      {mode, mpe, ren, tb8, rb8} <= 6'(sp4_pkg::RST_CTRL >> 2);
      ti <= 1'b0;
      ri <= 1'b0;
      {baud_double, tx_src, rx_src} <= 5'(sp4_pkg::RST_STAT);
      int_en <= 1'b0;
      rx_buf <= sp4_pkg::RST_BYTE;
      t1_reload <= sp4_pkg::RST_BYTE;
      my_addr <= sp4_pkg::RST_BYTE;
      my_mask <= sp4_pkg::RST_BYTE;
    end else begin
      ti <= next_ti;
      ri <= next_ri;
      if (wr_ctrl)
        {mode, mpe, ren, tb8} <= reg_wdata[7:3];
      if (rx_acc) begin
        rx_buf <= rx_data;
        rb8 <= rx_bit9;
      end else if (m0_fin) begin
        rx_buf <= m0_sh;
      end else if (wr_ctrl) begin
        rb8 <= reg_wdata[sp4_pkg::CTL_RB8];
      end
      if (wr_stat)
        {baud_double, tx_src, rx_src} <= reg_wdata[4:0];
      if (wr_ien)
        int_en <= reg_wdata[0];
      if (wr_t1)
        t1_reload <= reg_wdata;
      if (wr_addr)
        my_addr <= reg_wdata;
      if (wr_mask)
        my_mask <= reg_wdata;
    end
  end

  // Read mux; data stand only in the cycle after the strobe
  logic [7:0] rd_mux;
  always_comb begin
    case (a8)
      sp4_pkg::OFS_CTRL: rd_mux = ctrl_rd;
      sp4_pkg::OFS_BUF: rd_mux = rx_buf;
      sp4_pkg::OFS_STAT: rd_mux = stat_rd;
      sp4_pkg::OFS_IEN: rd_mux = {7'h00, int_en};
      sp4_pkg::OFS_T1RL: rd_mux = t1_reload;
      sp4_pkg::OFS_ADDR: rd_mux = my_addr;
      sp4_pkg::OFS_MASK: rd_mux = my_mask;
      default: rd_mux = 8'h00;
    endcase
  end

  // Pins; rx pin only ever pulled low so it is safe with a pull-up
  wire m0_drive_low = m0_act && !m0_rx && !m0_sh[0];
  wire m0_clk = !(m0_act && (m0_ph < sp4_pkg::M0_HALF));
  wire next_tx = is_m0 ? m0_clk : (!tx_busy || tx_sh[0]);
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
      serial_rx_pin_out <= 1'b0;
      serial_rx_pin_oe_n <= 1'b1;
      serial_tx_pin <= 1'b1;
      irq <= 1'b0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
      serial_rx_pin_out <= 1'b0;
      serial_rx_pin_oe_n <= !m0_drive_low;
      serial_tx_pin <= next_tx;
      irq <= int_en && (ti || ri);
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_m0_rate: assert property (
    m0_act && m0_ph == 4'h0 |-> ##11 (m0_ph == 4'hb))
    else $error("mode 0 bit time is not twelve clocks");
  a_m0_tx_done: assert property (
    m0_end && !m0_rx |=> ti)
    else $error("mode 0 transmit done flag not set");
  a_m0_rx_halt: assert property (
    is_m0 && ri && !m0_act && !wr_buf |=> !m0_act)
    else $error("mode 0 reception resumed with flag set");
  a_tx_stop_flag: assert property (
    tx_stop_now |=> ti ##1 serial_tx_pin)
    else $error("transmit flag not set at stop bit");
  a_tx_start_bit: assert property (
    tx_start |=> ##1 !serial_tx_pin)
    else $error("start bit missing after buffer write");
  a_rx_accept: assert property (
    rx_acc |=> ri && rx_buf == $past(rx_data))
    else $error("accepted frame not stored");
  a_rx_blocked: assert property (
    rx_last && ri && !m0_fin |=> $stable(rx_buf))
    else $error("buffer changed while flag set");
  a_od_low_only: assert property (
    !serial_rx_pin_oe_n |-> !serial_rx_pin_out && $past(is_m0))
    else $error("rx pin driven outside mode 0 or high");
  a_irq_req: assert property (
    int_en && (ti || ri) && !wr_ien |=> irq)
    else $error("interrupt not raised");

  c_m0_tx: cover property (m0_end && !m0_rx);
  c_rx_acc9: cover property (rx_acc && nine && mpe);
  c_rx_rej: cover property (rx_last && !rx_acc && !ri);
  c_dbl_tx: cover property (tx_stop_now && baud_double);
endmodule

// [hw/sp4_pkg.sv]
package sp4_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_BUF = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_IEN = 8'h0c;
  localparam logic [7:0] OFS_T1RL = 8'h10;
  localparam logic [7:0] OFS_ADDR = 8'h14;
  localparam logic [7:0] OFS_MASK = 8'h18;
  // Control register fields
  localparam int CTL_MODE_HI = 7;
  localparam int CTL_MODE_LO = 6;
  localparam int CTL_MPE = 5;
  localparam int CTL_REN = 4;
  localparam int CTL_TB8 = 3;
  localparam int CTL_RB8 = 2;
  localparam int CTL_TI = 1;
  localparam int CTL_RI = 0;
  // Status register fields
  localparam int STA_DBL = 4;
  localparam int STA_TSRC = 2;
  localparam int STA_RSRC = 0;
  // Reset values
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_STAT = 8'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // Modes
  typedef enum logic [1:0] {
    SP4_M0 = 2'h0,
    SP4_M1 = 2'h1,
    SP4_M2 = 2'h2,
    SP4_M3 = 2'h3
  } sp4_mode_t;
  // Baud sources
  localparam logic [1:0] SRC_T1 = 2'h0;
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int M0_DIV = 12;
  localparam logic [3:0] M0_LAST = 4'(M0_DIV - 1);
  localparam logic [3:0] M0_HALF = 4'(M0_DIV / 2);
  localparam int OS_RATE = 16;
  localparam logic [3:0] OS_LAST = 4'(OS_RATE - 1);
  localparam logic [3:0] OS_MID = 4'(OS_RATE / 2 - 1);
  localparam logic [1:0] FIX_LAST_SLOW = 2'(64 / OS_RATE - 1);
  localparam logic [1:0] FIX_LAST_FAST = 2'(32 / OS_RATE - 1);
  localparam logic [7:0] T1_TOP = 8'hff;
  localparam logic [3:0] BITS_8N = 4'ha;
  localparam logic [3:0] BITS_9N = 4'hb;
  localparam logic [2:0] M0_BITS_LAST = 3'h7;
endpackage

// [hw/sp4_baud_if.sv]
`timescale 1ns/1ns
interface sp4_baud_if;
  logic [1:0] src;
  logic tick;
  modport gen(input src, output tick);
  modport user(output src, input tick);
endinterface

// [hw/sp4_baud_gen.sv]
`timescale 1ns/1ns
module sp4_baud_gen (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [3:0] ovf,
  input wire logic fixed_rate,
  input wire logic baud_double,
  sp4_baud_if.gen bif
);
  logic [1:0] fcnt;
  logic half;
  wire [1:0] fix_last = baud_double ? sp4_pkg::FIX_LAST_FAST
                                    : sp4_pkg::FIX_LAST_SLOW;
  wire sel_ovf = ovf[bif.src];
  wire t1_halve = (bif.src == sp4_pkg::SRC_T1) && !baud_double;
  wire fix_tick = (fcnt == fix_last);
  wire next_tick = fixed_rate ? fix_tick
                              : (sel_ovf && (!t1_halve || half));
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      fcnt <= 2'h0;
      half <= 1'b0;
      bif.tick <= 1'b0;
    end else begin
      fcnt <= fix_tick ? 2'h0 : fcnt + 2'h1;
      if (sel_ovf && t1_halve)
        half <= ~half;
      bif.tick <= next_tick;
    end
  end
endmodule

// [verif/sp4_serial_partner.sv]
`timescale 1ns/1ns
module sp4_serial_partner (
  input wire logic clk_sys,
  input wire logic serial_tx_pin,
  input wire logic serial_rx_pin_out,
  input wire logic serial_rx_pin_oe_n,
  input wire logic irq,
  output logic rx_line
);
  logic drv = 1'b1;
  // Waits that ran out; the bench checks this is still zero
  int lost = 0;
  // Pull-up wins unless either side pulls low
  assign rx_line = drv & (serial_rx_pin_oe_n | serial_rx_pin_out);

  // Bounded wait for a tx pin level, counting falling clock edges seen
  task automatic wait_tx(input logic lvl, output bit ok, output int n);
    ok = 1'b0;
    for (n = 0; n < 4000 && !ok; ) begin
      @(negedge clk_sys);
      n++;
      ok = (serial_tx_pin === lvl);
    end
    if (!ok) lost++;
  endtask

  task automatic recv_frame(input int nb, input int per,
                            output logic [9:0] w, output logic [1:0] ia);
    bit ok;
    int n;
    w = 'x;
    ia = 'x;
    wait_tx(1'b0, ok, n);
    if (!ok) return;
    repeat (per / 2) @(negedge clk_sys);
    w = 10'h000;
    for (int i = 0; i < nb; i++) begin
      repeat (per) @(negedge clk_sys);
      w[i] = serial_tx_pin;
      if (i >= nb - 2) ia[nb - 1 - i] = irq;
    end
  endtask

  task automatic send_frame(input int nb, input logic [9:0] w, input int per);
    @(posedge clk_sys);
    drv <= 1'b0;
    for (int i = 0; i < nb; i++) begin
      repeat (per) @(posedge clk_sys);
      drv <= w[i];
    end
    repeat (per) @(posedge clk_sys);
    drv <= 1'b1;
    // Idle gap so the next start bit is a clean falling edge
    repeat (per) @(posedge clk_sys);
  endtask

  task automatic m0_recv(output logic [7:0] d, output int span);
    bit ok;
    int n;
    d = 'x;
    span = 0;
    wait_tx(1'b0, ok, n);
    for (int i = 0; i < 8 && ok; i++) begin
      wait_tx(1'b1, ok, n);
      span += n;
      d[i] = rx_line;
      if (i < 7) begin
        wait_tx(1'b0, ok, n);
        span += n;
      end
    end
  endtask

  // Data changes on the falling shift clock, well clear of sampling
  task automatic m0_send(input logic [7:0] d);
    bit ok;
    int n;
    for (int i = 0; i < 8; i++) begin
      wait_tx(1'b0, ok, n);
      drv = d[i];
      wait_tx(1'b1, ok, n);
    end
    repeat (12) @(negedge clk_sys);
    drv = 1'b1;
  endtask
endmodule

// [verif/sp4_serial_port_tb_top.sv]
`timescale 1ns/1ns
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin \
  err_count++; $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end

module sp4_serial_port_tb_top;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic timer1_input_clock = 1'b1;
  logic [2:0] wide_timer_ovf = 3'h0;
  logic [2:0] tcnt = 3'h0;
  logic [7:0] reg_rdata;
  logic rx_line;
  logic rx_out;
  logic rx_oe_n;
  logic tx_pin;
  logic irq;
  logic [7:0] d;
  logic [9:0] w;
  logic [1:0] ia;
  int span;
  int k;
  int err_count = 0;
  int num_checks = 0;

  sp4_serial_port u_sp4_serial_port (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .timer1_input_clock(timer1_input_clock),
    .wide_timer_ovf(wide_timer_ovf),
    .serial_rx_pin_in(rx_line),
    .serial_rx_pin_out(rx_out),
    .serial_rx_pin_oe_n(rx_oe_n),
    .serial_tx_pin(tx_pin),
    .irq(irq)
  );

  sp4_serial_partner u_sp4_serial_partner (
    .clk_sys(clk_sys),
    .serial_tx_pin(tx_pin),
    .serial_rx_pin_out(rx_out),
    .serial_rx_pin_oe_n(rx_oe_n),
    .irq(irq),
    .rx_line(rx_line)
  );

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  // Wide timers overflow every 4, 8, 2 cycles; timer 1 ticks every other
  always @(posedge clk_sys) begin
    tcnt <= tcnt + 3'h1;
    timer1_input_clock <= ~timer1_input_clock;
    wide_timer_ovf <= {tcnt[0], tcnt == 3'h7, tcnt[1:0] == 2'h3};
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    `CHK(v, e)
  endtask

  task automatic results();
    $display("checks=%0d mismatches=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge clk_sys);
    err_count++;
    results();
  end

  initial begin
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    chk_rd(sp4_pkg::OFS_CTRL, sp4_pkg::RST_CTRL);
    chk_rd(sp4_pkg::OFS_STAT, sp4_pkg::RST_STAT);
    chk_rd(8'h1c, 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr(sp4_pkg::OFS_CTRL, {2'(m), 6'h00});
      chk_rd(sp4_pkg::OFS_CTRL, {2'(m), 6'h00});
    end
    $display("test reset and mode done");
    // Tx on timer 1 (8-cycle overflow, undoubled), rx on timer 2
    wr(sp4_pkg::OFS_T1RL, 8'hfc);
    // Reload only applies after the first roll from zero
    repeat (600) @(posedge clk_sys);
    wr(sp4_pkg::OFS_STAT, 8'h01);
    wr(sp4_pkg::OFS_IEN, 8'h01);
    wr(sp4_pkg::OFS_CTRL, 8'h40);
    fork
      wr(sp4_pkg::OFS_BUF, 8'h6e);
      u_sp4_serial_partner.recv_frame(9, 256, w, ia);
    join
    `CHK(w[8:0], {1'b1, 8'h6e})
    `CHK(ia, 2'b01)
    chk_rd(sp4_pkg::OFS_CTRL, 8'h42);
    $display("test mode1 tx done");
    wr(sp4_pkg::OFS_CTRL, 8'h70);
    u_sp4_serial_partner.send_frame(9, {1'b0, 8'h3c}, 64);
    chk_rd(sp4_pkg::OFS_CTRL, 8'h70);
    u_sp4_serial_partner.send_frame(9, {1'b1, 8'hc3}, 64);
    chk_rd(sp4_pkg::OFS_BUF, 8'hc3);
    chk_rd(sp4_pkg::OFS_CTRL, 8'h75);
    `CHK(irq, 1'b1)
    // Flag still set, so this frame must be dropped
    u_sp4_serial_partner.send_frame(9, {1'b1, 8'h11}, 64);
    chk_rd(sp4_pkg::OFS_BUF, 8'hc3);
    $display("test mode1 rx done");
    wr(sp4_pkg::OFS_STAT, 8'h10);
    wr(sp4_pkg::OFS_CTRL, 8'h98);
    fork
      wr(sp4_pkg::OFS_BUF, 8'ha5);
      u_sp4_serial_partner.recv_frame(10, 32, w, ia);
    join
    `CHK(w, {2'b11, 8'ha5})
    `CHK(ia, 2'b01)
    u_sp4_serial_partner.send_frame(10, {2'b00, 8'h5c}, 32);
    chk_rd(sp4_pkg::OFS_BUF, 8'h5c);
    chk_rd(sp4_pkg::OFS_CTRL, 8'h9b);
    $display("test mode2 done");
    // Rx on timer 4, 2-cycle overflow, address 0x35 mask 0x0f
    wr(sp4_pkg::OFS_ADDR, 8'h35);
    wr(sp4_pkg::OFS_MASK, 8'h0f);
    wr(sp4_pkg::OFS_STAT, 8'h03);
    wr(sp4_pkg::OFS_CTRL, 8'hf0);
    u_sp4_serial_partner.send_frame(10, {2'b11, 8'h26}, 32);
    u_sp4_serial_partner.send_frame(10, {2'b10, 8'h15}, 32);
    chk_rd(sp4_pkg::OFS_CTRL, 8'hf0);
    u_sp4_serial_partner.send_frame(10, {2'b11, 8'ha5}, 32);
    chk_rd(sp4_pkg::OFS_BUF, 8'ha5);
    chk_rd(sp4_pkg::OFS_CTRL, 8'hf5);
    // Mode 3 send on timer 3, ninth bit clear
    wr(sp4_pkg::OFS_STAT, 8'h0b);
    wr(sp4_pkg::OFS_CTRL, 8'hc0);
    fork
      wr(sp4_pkg::OFS_BUF, 8'h3c);
      u_sp4_serial_partner.recv_frame(10, 128, w, ia);
    join
    `CHK(w, {2'b10, 8'h3c})
    `CHK(ia, 2'b01)
    $display("test mode3 done");
    wr(sp4_pkg::OFS_CTRL, 8'h00);
    fork
      wr(sp4_pkg::OFS_BUF, 8'h96);
      u_sp4_serial_partner.m0_recv(d, span);
    join
    `CHK(d, 8'h96)
    `CHK(span, 90)
    `CHK(rx_out, 1'b0)
    repeat (8) @(posedge clk_sys);
    chk_rd(sp4_pkg::OFS_CTRL, 8'h02);
    fork
      wr(sp4_pkg::OFS_CTRL, 8'h10);
      u_sp4_serial_partner.m0_send(8'h5a);
    join
    chk_rd(sp4_pkg::OFS_BUF, 8'h5a);
    chk_rd(sp4_pkg::OFS_CTRL, 8'h11);
    k = 0;
    repeat (60) begin
      @(negedge clk_sys);
      if (tx_pin === 1'b1) k++;
    end
    `CHK(k, 60)
    $display("test mode0 done");
    `CHK(u_sp4_serial_partner.lost, 0)
    results();
  end
endmodule
